// ==== mpss_top.sv ====
// Staging sequencer for a constant-pressure drive with up to two followers.
`timescale 1ns/1ns

module mpss_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] pressure,
  input  wire logic [15:0] out_freq,
  input  wire logic        run_after_second_off,
  input  wire logic [1:0]  relay_fn_out,
  output logic      [1:0]  relay_out,
  output logic             controller_sleep,
  output logic             freq_override,
  output logic      [15:0] freq_override_value
);
  import mpss_pkg::*;

  mpss_cfg_t   cfg;            // Register-held configuration.
  mpss_phase_t phase;          // Regulation or hold phase.
  logic [15:0] pres_s1, pres;  // Pressure synchroniser.
  logic [15:0] freq_s1, freq;  // Frequency synchroniser.
  logic        run2_s1, run2;  // Second-off-cycle flag synchroniser.
  logic [15:0] tick_cnt;       // Millisecond prescaler.
  logic        tick;           // One-cycle millisecond strobe.
  logic [1:0]  rot;            // Rotation index, which order is in use.
  logic [1:0]  staged;         // Units currently in service.
  logic [1:0]  n_units;        // Units in sequencing beyond the primary.
  logic        mux_en, mux_en_q;
  logic        low_p, high_p, win_f, sleep_ok;
  logic        rot_done, sdly_done, ddly_done, hold_done, run_done;
  logic [31:0] hold_lim;
  mpss_unit_t  order [3];      // Staging order for current rotation.
  mpss_unit_t  next_up, next_down;
  logic [15:0] run_lim;

  // ----------------------------------------------------------------
  // Register slave.
  // ----------------------------------------------------------------
  mpss_ahb_regs u_regs (
    .clk         (clk),
    .nrst        (nrst),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hready),
    .hrdata      (hrdata),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .meas_word   ({freq, pres}),
    .status_word ({22'h00_0000, phase, rot, staged, relay_out, controller_sleep, mux_en}),
    .cfg         (cfg)
  );

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  // Measured values come from another domain; a multi-bit word may tear on one
  // sample, which the delay timers tolerate because they need a steady level.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pres_s1 <= 16'h0000;
      pres    <= 16'h0000;
      freq_s1 <= 16'h0000;
      freq    <= 16'h0000;
      run2_s1 <= 1'b0;
      run2    <= 1'b0;
    end else begin
      pres_s1 <= pressure;
      pres    <= pres_s1;
      freq_s1 <= out_freq;
      freq    <= freq_s1;
      run2_s1 <= run_after_second_off;
      run2    <= run2_s1;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  assign tick = (tick_cnt == 16'(MPSS_TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // Conditions.
  // ----------------------------------------------------------------
  // Follower count clamped to the two relays that exist.
  logic [1:0] lag;
  assign lag = (cfg.lag_count > MPSS_MAX_FOLLOWERS) ? MPSS_MAX_FOLLOWERS : cfg.lag_count;
  logic standby1;
  assign standby1 = (cfg.relay1_fn == MPSS_RELAY_FN_STANDBY);

  assign mux_en = (lag != 2'd0) && (cfg.rot_period != MPSS_ZERO32)
                  && cfg.constant_pressure_mode;
  assign low_p  = {1'b0, pres} <= ({1'b0, cfg.target} - {1'b0, cfg.stage_pressure_offset});
  assign high_p = {1'b0, pres} >= ({1'b0, cfg.target} + {1'b0, cfg.destage_pressure_offset});
  assign win_f  = (freq >= cfg.floor_freq) &&
                  ({1'b0, freq} <= ({1'b0, cfg.floor_freq} + {1'b0, cfg.destage_freq_window}));
  assign run_lim  = run2 ? cfg.min_run_time_second : cfg.min_run_time_first;
  assign sleep_ok = (pres >= cfg.target) &&
                    ({1'b0, freq} <= ({1'b0, cfg.floor_freq} + {1'b0, cfg.sleep_margin}));

  // ----------------------------------------------------------------
  // Staging order.
  // ----------------------------------------------------------------
  // The controller is second whenever a follower leads; a standby relay one is
  // dropped from the list while the rest move up in the same order.
  always_comb begin
    order[0] = MPSS_UNIT_CTRL;
    order[1] = MPSS_UNIT_F1;
    order[2] = MPSS_UNIT_F2;
    if (lag == 2'd1) begin
      order[2] = MPSS_UNIT_NONE;
      if (rot == 2'd1) begin
        order[0] = MPSS_UNIT_F1;
        order[1] = MPSS_UNIT_CTRL;
      end
    end else if (rot == 2'd1) begin
      order[0] = MPSS_UNIT_F1;
      order[1] = MPSS_UNIT_CTRL;
    end else if (rot == 2'd2) begin
      order[0] = MPSS_UNIT_F2;
      order[1] = MPSS_UNIT_CTRL;
      order[2] = MPSS_UNIT_F1;
    end
    if (standby1) begin
      if (order[0] == MPSS_UNIT_F1) order[0] = order[1];
      if (order[1] == MPSS_UNIT_F1 || order[1] == order[0]) order[1] = order[2];
      if (order[2] == MPSS_UNIT_F1 || order[2] == order[1]) order[2] = MPSS_UNIT_NONE;
    end
  end

  assign n_units   = lag - 2'(standby1 && lag != 2'd0);
  assign next_up   = (staged > n_units) ? MPSS_UNIT_NONE : order[staged];
  assign next_down = (staged == 2'd0) ? MPSS_UNIT_NONE : order[staged - 2'd1];

  // ----------------------------------------------------------------
  // Timers.
  // ----------------------------------------------------------------
  mpss_timer #(.W(32)) u_rot (.clk(clk), .nrst(nrst), .run(mux_en && !rot_done),
    .tick(tick), .limit(cfg.rot_period), .done(rot_done));
  mpss_timer #(.W(32)) u_sdly (.clk(clk), .nrst(nrst),
    .run(low_p && phase == MPSS_REGULATE), .tick(tick),
    .limit(cfg.stage_delay), .done(sdly_done));
  mpss_timer #(.W(32)) u_ddly (.clk(clk), .nrst(nrst),
    .run(high_p && win_f && phase == MPSS_REGULATE), .tick(tick),
    .limit(cfg.destage_delay), .done(ddly_done));
  mpss_timer #(.W(32)) u_hold (.clk(clk), .nrst(nrst),
    .run(phase != MPSS_REGULATE), .tick(tick), .limit(hold_lim), .done(hold_done));
  mpss_timer #(.W(16)) u_run (.clk(clk), .nrst(nrst), .run(!controller_sleep),
    .tick(tick), .limit(run_lim), .done(run_done));

  // ----------------------------------------------------------------
  // Rotation index.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rot      <= 2'd0;
      mux_en_q <= 1'b0;
    end else begin
      mux_en_q <= mux_en;
      if (!mux_en || rot > lag) begin
        rot <= 2'd0;
      end else if (rot_done) begin
        rot <= (rot >= lag) ? 2'd0 : rot + 2'd1;
        if (standby1 && ((rot >= lag) ? 2'd0 : rot + 2'd1) == 2'd1) begin
          rot <= (lag == 2'd2) ? 2'd2 : 2'd0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Stage and destage sequencing.
  // ----------------------------------------------------------------
  logic go_up, go_down;
  assign go_up   = phase == MPSS_REGULATE && next_up != MPSS_UNIT_NONE && low_p &&
                   (staged == 2'd0 || sdly_done);
  assign go_down = phase == MPSS_REGULATE && next_down != MPSS_UNIT_NONE && ddly_done;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase               <= MPSS_REGULATE;
      staged              <= 2'd0;
      relay_out           <= 2'b00;
      controller_sleep    <= 1'b0;
      freq_override       <= 1'b0;
      freq_override_value <= 16'h0000;
      hold_lim            <= MPSS_ZERO32;
    end else if (!mux_en) begin
      // Without multiplex the relays follow their own configured function.
      phase            <= MPSS_REGULATE;
      staged           <= 2'd0;
      relay_out        <= relay_fn_out;
      freq_override    <= 1'b0;
      controller_sleep <= sleep_ok && run_done;
    end else begin
      // Entering multiplex drops whatever the relays' own functions left closed, bar a standby relay one,
      // so a pass-through contact can never masquerade as a staged follower.
      if (!mux_en_q) begin
        relay_out <= 2'b00;
      end
      case (phase)
        MPSS_REGULATE: begin
          freq_override <= 1'b0;
          if (go_up) begin
            staged <= staged + 2'd1;
            if (next_up == MPSS_UNIT_CTRL) begin
              controller_sleep <= 1'b0;
              phase <= MPSS_REGULATE;
            end else begin
              relay_out[next_up == MPSS_UNIT_F2] <= 1'b1;
              freq_override       <= 1'b1;
              freq_override_value <= cfg.ceil_freq -
                (next_up == MPSS_UNIT_F1 ? cfg.fol1.drop : cfg.fol2.drop);
              hold_lim <= {16'h0000,
                (next_up == MPSS_UNIT_F1 ? cfg.fol1.hold : cfg.fol2.hold)};
              phase <= MPSS_STAGE_HOLD;
            end
          end else if (go_down) begin
            staged <= staged - 2'd1;
            if (next_down == MPSS_UNIT_CTRL) begin
              controller_sleep <= 1'b1;
            end else begin
              relay_out[next_down == MPSS_UNIT_F2] <= 1'b0;
            end
            freq_override       <= 1'b1;
            freq_override_value <= freq + cfg.destage_freq_rise;
            hold_lim            <= cfg.destage_hold_time;
            phase               <= MPSS_DESTAGE_HOLD;
          end
        end
        MPSS_STAGE_HOLD, MPSS_DESTAGE_HOLD: begin
          if (hold_done) begin
            freq_override <= 1'b0;
            phase         <= MPSS_REGULATE;
          end
        end
        default: phase <= MPSS_REGULATE;
      endcase
      if (standby1) begin
        relay_out[0] <= relay_fn_out[0];
      end
    end
  end
endmodule

// ==== mpss_pkg.sv ====
// Package of types and constants for the pump stage sequencer.
package mpss_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AHB-Lite slave.
  // ----------------------------------------------------------------
  localparam logic [7:0] MPSS_OFS_CTRL       = 8'h00; // Mode, unit count, relay function.
  localparam logic [7:0] MPSS_OFS_TARGET     = 8'h04; // Pressure target.
  localparam logic [7:0] MPSS_OFS_PRESS_OFS  = 8'h08; // Stage and destage pressure offsets.
  localparam logic [7:0] MPSS_OFS_FREQ_LIM   = 8'h0C; // Floor and ceiling frequency.
  localparam logic [7:0] MPSS_OFS_FREQ_ADJ   = 8'h10; // Window, rise, sleep margin.
  localparam logic [7:0] MPSS_OFS_STG_DELAY  = 8'h14; // Stage delay, ms.
  localparam logic [7:0] MPSS_OFS_DSTG_DELAY = 8'h18; // Destage delay, ms.
  localparam logic [7:0] MPSS_OFS_DSTG_HOLD  = 8'h1C; // Destage hold time, ms.
  localparam logic [7:0] MPSS_OFS_ROT_PERIOD = 8'h20; // Rotation period, ms.
  localparam logic [7:0] MPSS_OFS_MIN_RUN    = 8'h24; // First and second minimum run time, ms.
  localparam logic [7:0] MPSS_OFS_FOL1       = 8'h28; // Follower 1 drop and hold.
  localparam logic [7:0] MPSS_OFS_FOL2       = 8'h2C; // Follower 2 drop and hold.
  localparam logic [7:0] MPSS_OFS_MEAS       = 8'h30; // Measured pressure and frequency.
  localparam logic [7:0] MPSS_OFS_STATUS     = 8'h34; // Read-only state.

  // ----------------------------------------------------------------
  // Field constants.
  // ----------------------------------------------------------------
  localparam logic [3:0]  MPSS_RELAY_FN_STANDBY = 4'h6;       // Relay one standby pump.
  localparam logic [1:0]  MPSS_MAX_FOLLOWERS    = 2'h2;       // Follower ceiling.
  localparam logic [31:0] MPSS_ZERO32           = 32'h0000_0000;
  localparam int          MPSS_CLK_HZ           = 50_000_000; // System clock rate.
  localparam int          MPSS_MS               = 1;          // Tick unit, one millisecond.
  localparam int          MPSS_TICK_CYCLES      = MPSS_CLK_HZ / 1000 * MPSS_MS;

  // Sequencer phases.
  typedef enum logic [1:0] {
    MPSS_REGULATE,
    MPSS_STAGE_HOLD,
    MPSS_DESTAGE_HOLD
  } mpss_phase_t;

  // Unit identifiers: controller, follower 1 or 2, or none.
  typedef enum logic [1:0] {
    MPSS_UNIT_CTRL,
    MPSS_UNIT_F1,
    MPSS_UNIT_F2,
    MPSS_UNIT_NONE
  } mpss_unit_t;

  // Per-follower staging settings.
  typedef struct packed {
    logic [15:0] drop;   // Stage frequency drop.
    logic [15:0] hold;   // Stage hold time, ms.
  } mpss_fol_cfg_t;

  // Configuration carried from the register file into the sequencer.
  typedef struct packed {
    logic        constant_pressure_mode;
    logic [1:0]  lag_count;
    logic [3:0]  relay1_fn;
    logic [15:0] target;
    logic [15:0] stage_pressure_offset;
    logic [15:0] destage_pressure_offset;
    logic [15:0] floor_freq;
    logic [15:0] ceil_freq;
    logic [15:0] destage_freq_window;
    logic [15:0] destage_freq_rise;
    logic [15:0] sleep_margin;
    logic [31:0] stage_delay;
    logic [31:0] destage_delay;
    logic [31:0] destage_hold_time;
    logic [31:0] rot_period;
    logic [15:0] min_run_time_first;
    logic [15:0] min_run_time_second;
    mpss_fol_cfg_t fol1;
    mpss_fol_cfg_t fol2;
  } mpss_cfg_t;

endpackage

// ==== mpss_timer.sv ====
// Millisecond down-free elapsed timer with restart and compare.
`timescale 1ns/1ns
module mpss_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  import mpss_pkg::*;

  logic [W-1:0] count; // Elapsed ticks since run rose.

  // ----------------------------------------------------------------
  // Counting.
  // ----------------------------------------------------------------
  // Count stops at the limit so that it never wraps to a false short period.
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      count <= '0;
    end else if (tick && count < limit) begin
      count <= count + 1'b1;
    end
  end

  // Done is a level while run holds and the limit has been reached.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done <= 1'b0;
    end else begin
      done <= run && (count >= limit);
    end
  end
endmodule

// ==== mpss_ahb_regs.sv ====
// AHB-Lite register slave for the pump stage sequencer.
`timescale 1ns/1ns
module mpss_ahb_regs (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [31:0]        meas_word,
  input  wire logic [31:0]        status_word,
  output mpss_pkg::mpss_cfg_t     cfg
);
  import mpss_pkg::*;

  logic       wr_pend;  // Write data phase pending.
  logic [7:0] wr_addr;  // Latched write offset.
  logic       rd_go;    // Read address phase accepted.
  logic [7:0] a;        // Low address bits.

  assign a = haddr[7:0];

  // ----------------------------------------------------------------
  // Address phase capture.
  // ----------------------------------------------------------------
  // Zero wait states: always ready, always OKAY.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      rd_go     <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      rd_go   <= hsel && htrans[1] && hready && !hwrite;
      wr_addr <= a;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Writes in the data phase.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        MPSS_OFS_CTRL: begin
          cfg.constant_pressure_mode <= hwdata[0];
          cfg.lag_count              <= hwdata[5:4];
          cfg.relay1_fn              <= hwdata[11:8];
        end
        MPSS_OFS_TARGET:     cfg.target <= hwdata[15:0];
        MPSS_OFS_PRESS_OFS: begin
          cfg.stage_pressure_offset   <= hwdata[15:0];
          cfg.destage_pressure_offset <= hwdata[31:16];
        end
        MPSS_OFS_FREQ_LIM: begin
          cfg.floor_freq <= hwdata[15:0];
          cfg.ceil_freq  <= hwdata[31:16];
        end
        MPSS_OFS_FREQ_ADJ: begin
          cfg.destage_freq_window <= {8'h00, hwdata[7:0]};
          cfg.destage_freq_rise   <= {8'h00, hwdata[15:8]};
          cfg.sleep_margin        <= hwdata[31:16];
        end
        MPSS_OFS_STG_DELAY:  cfg.stage_delay       <= hwdata;
        MPSS_OFS_DSTG_DELAY: cfg.destage_delay     <= hwdata;
        MPSS_OFS_DSTG_HOLD:  cfg.destage_hold_time <= hwdata;
        MPSS_OFS_ROT_PERIOD: cfg.rot_period        <= hwdata;
        MPSS_OFS_MIN_RUN: begin
          cfg.min_run_time_first  <= hwdata[15:0];
          cfg.min_run_time_second <= hwdata[31:16];
        end
        MPSS_OFS_FOL1: cfg.fol1 <= hwdata;
        MPSS_OFS_FOL2: cfg.fol2 <= hwdata;
        default: begin
          // Read-only and unmapped offsets ignore writes.
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered for the data phase.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= MPSS_ZERO32;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      case (a)
        MPSS_OFS_CTRL:       hrdata <= {20'h0_0000, cfg.relay1_fn, 2'b00, cfg.lag_count,
                                        3'b000, cfg.constant_pressure_mode};
        MPSS_OFS_TARGET:     hrdata <= {16'h0000, cfg.target};
        MPSS_OFS_PRESS_OFS:  hrdata <= {cfg.destage_pressure_offset, cfg.stage_pressure_offset};
        MPSS_OFS_FREQ_LIM:   hrdata <= {cfg.ceil_freq, cfg.floor_freq};
        MPSS_OFS_FREQ_ADJ:   hrdata <= {cfg.sleep_margin, cfg.destage_freq_rise[7:0],
                                        cfg.destage_freq_window[7:0]};
        MPSS_OFS_STG_DELAY:  hrdata <= cfg.stage_delay;
        MPSS_OFS_DSTG_DELAY: hrdata <= cfg.destage_delay;
        MPSS_OFS_DSTG_HOLD:  hrdata <= cfg.destage_hold_time;
        MPSS_OFS_ROT_PERIOD: hrdata <= cfg.rot_period;
        MPSS_OFS_MIN_RUN:    hrdata <= {cfg.min_run_time_second, cfg.min_run_time_first};
        MPSS_OFS_FOL1:       hrdata <= cfg.fol1;
        MPSS_OFS_FOL2:       hrdata <= cfg.fol2;
        MPSS_OFS_MEAS:       hrdata <= meas_word;
        MPSS_OFS_STATUS:     hrdata <= status_word;
        default:             hrdata <= MPSS_ZERO32;
      endcase
    end else if (!rd_go) begin
      hrdata <= MPSS_ZERO32;
    end
  end
endmodule

// ==== mpss_checker.sv ====
// Port assertions for the pump stage sequencer.
`timescale 1ns/1ns
module mpss_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [1:0]  relay_fn_out,
  input wire logic [1:0]  relay_out,
  input wire logic        controller_sleep,
  input wire logic        freq_override,
  input wire logic [15:0] freq_override_value
);
  // All checks share the one system clock and its reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_reset_clear;
    $rose(nrst) |-> relay_out == 2'b00 && !freq_override && !controller_sleep;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
  // A pass-through edge may flip a bit, so only steady relay functions are judged.
  property p_one_step;
    $stable(relay_fn_out) |-> $onehot0(relay_out ^ $past(relay_out));
  endproperty
  a_one_step: assert property (p_one_step) else $error("two units moved");
  property p_hold_no_step;
    freq_override && $past(freq_override) && $past(freq_override, 2) |-> $stable(relay_out);
  endproperty
  a_hold_no_step: assert property (p_hold_no_step) else $error("step in hold");
  property p_hold_sleep;
    freq_override && $past(freq_override) && $past(freq_override, 2) |-> $stable(controller_sleep);
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("sleep moved in hold");
  property p_hold_value;
    freq_override && $past(freq_override) |-> $stable(freq_override_value);
  endproperty
  a_hold_value: assert property (p_hold_value) else $error("hold value moved");
  property p_value_set;
    freq_override |-> freq_override_value != 16'h0000;
  endproperty
  a_value_set: assert property (p_value_set) else $error("hold value empty");
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_resp;
    !hresp;
  endproperty
  a_resp: assert property (p_resp) else $error("error response seen");
  c_stage: cover property ($rose(relay_out[0]));
  c_hold: cover property ($rose(freq_override));
  c_both: cover property (relay_out == 2'b11);
endmodule

// ==== mpss_fol_model.sv ====
// Behavioural model of two follower drives switched by relay contacts.
`timescale 1ns/1ns
module mpss_fol_model #(
  parameter int DLY = 2 // Contact-to-run delay in cycles; larger models a slow starter.
) (
  input  wire logic       clk,
  input  wire logic [1:0] relay_out,
  output logic      [1:0] running
);
  logic [1:0] pipe [DLY]; // Each follower's run state is its own contact delayed by DLY cycles.
  always_ff @(posedge clk) begin
    pipe[0] <= relay_out;
    for (int i = 1; i < DLY; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign running = pipe[DLY-1];
endmodule

// ==== tb_multiplex_pump_stage_sequencer.sv ====
// Self-checking bench for the pump stage sequencer.
`timescale 1ns/1ns
module tb_multiplex_pump_stage_sequencer;
  import mpss_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0, run_after_second_off = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic [15:0] pressure = 16'h0064, out_freq = 16'h003C, freq_override_value;
  logic [1:0]  htrans = 2'b00, relay_fn_out = 2'b00, relay_out, running;
  logic        hreadyout, hresp, controller_sleep, freq_override;
  wire logic   hready = hreadyout;
  int          num_errors = 0, num_checks = 0;
  mpss_top DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pressure(pressure), .out_freq(out_freq),
    .run_after_second_off(run_after_second_off), .relay_fn_out(relay_fn_out),
    .relay_out(relay_out), .controller_sleep(controller_sleep), .freq_override(freq_override),
    .freq_override_value(freq_override_value));
  mpss_fol_model #(.DLY(2)) u_fol (.clk(clk), .relay_out(relay_out), .running(running));
  always #10 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single AHB-Lite transfer; the address phase is held until hready.
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wait_relay(input logic [1:0] v, input int n);
    for (int k = 0; k < n && relay_out !== v; k++) @(posedge clk);
    check("relay_out", {30'h0, v}, {30'h0, relay_out});
  endtask
  // Settings: target 100, offsets 10, floor 30, ceiling 60, rotation 100 ms, follower 1 hold 1 ms, other holds 0.
  task automatic t_regs;
    logic [31:0] v [11] = '{32'h0000_0064, 32'h000A_000A, 32'h003C_001E, 32'h0000_0505,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0064, 32'hFFFF_FFFF,
      32'h0005_0001, 32'h0005_0000};
    check("relay_out", 32'h0000_0000, {30'h0, relay_out});
    for (int i = 0; i < 11; i++) ahb(8'h04 + 8'(4 * i), 1'b1, v[i]);
    ahb(MPSS_OFS_TARGET, 1'b0, 32'h0000_0000);
    check("target", 32'h0000_0064, q);
    ahb(8'h3C, 1'b0, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, q);
  endtask
  task automatic t_modes;
    relay_fn_out <= 2'b01;
    wait_relay(2'b01, 20);
    ahb(MPSS_OFS_CTRL, 1'b1, 32'h0000_0020);
    repeat (300) @(posedge clk);
    check("relay_out", 32'h0000_0001, {30'h0, relay_out});
  endtask
  task automatic t_stage;
    ahb(MPSS_OFS_CTRL, 1'b1, 32'h0000_0021);
    repeat (5) @(posedge clk);
    check("relay_out", 32'h0000_0000, {30'h0, relay_out});
    pressure <= 16'h0050;
    wait_relay(2'b01, 2000);
    check("override", 32'h0001_0037, {15'h0, freq_override, freq_override_value});
    repeat (100) @(posedge clk);
    check("relay_out", 32'h0000_0001, {30'h0, relay_out});
    wait_relay(2'b11, 60000);
  endtask
  task automatic t_destage;
    pressure <= 16'h0078;
    repeat (300) @(posedge clk);
    check("relay_out", 32'h0000_0003, {30'h0, relay_out});
    out_freq <= 16'h0020;
    wait_relay(2'b01, 2000);
    check("override", 32'h0001_0025, {15'h0, freq_override, freq_override_value});
    wait_relay(2'b00, 2000);
    repeat (3) @(posedge clk);
    check("running", 32'h0000_0000, {30'h0, running});
    repeat (10) @(posedge clk);
    check("sleep", 32'h0000_0001, {31'h0, controller_sleep});
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_stage();
    t_destage();
    tally_and_finish();
  end
endmodule
bind mpss_top mpss_checker u_chk (.clk(clk), .nrst(nrst), .hreadyout(hreadyout),
  .hresp(hresp), .relay_fn_out(relay_fn_out), .relay_out(relay_out),
  .controller_sleep(controller_sleep), .freq_override(freq_override),
  .freq_override_value(freq_override_value));
